// ==== logic/smap_pkg.sv ====
// package for the peripheral-register paging and memory map block
// assumes one core clock shared by core, peripherals and this block
package smap_pkg;
   typedef enum logic [3:0] {
      SMAP_NOP, SMAP_DIR_RD, SMAP_DIR_WR, SMAP_IND_RD, SMAP_IND_WR,
      SMAP_REG_RD, SMAP_REG_WR, SMAP_PUSH, SMAP_POP, SMAP_CALL, SMAP_RET,
      SMAP_XDATA_RD, SMAP_XDATA_WR, SMAP_FETCH, SMAP_SFR_IND
   } smap_cmd_t;

   typedef struct packed {
      smap_cmd_t cmd;
      logic [15:0] addr;
      logic [7:0] data;
   } smap_req_t;

   typedef struct packed {
      logic valid;
      logic accLoad;
      logic [15:0] data;
   } smap_rsp_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic page;
      logic [7:0] addr;
      logic [7:0] data;
   } smap_sfr_t;

   typedef struct packed {
      logic dataRd;
      logic dataWr;
      logic fetch;
      logic [15:0] addr;
      logic [7:0] data;
   } smap_ext_t;

   localparam logic [7:0] SMAP_ADDR_SP = 8'h81;
   localparam logic [7:0] SMAP_ADDR_POWER_CONTROL_REGISTER = 8'h87;
   localparam logic [7:0] SMAP_ADDR_PEN2 = 8'hB1;
   localparam logic [7:0] SMAP_ADDR_PSW = 8'hD0;
   localparam logic [7:0] SMAP_ADDR_MEMCFG = 8'hF6;
   localparam logic [7:0] SMAP_ADDR_FLAGS = 8'hF8;

   localparam logic [7:0] SMAP_RST_SP = 8'h07;
   localparam logic [7:0] SMAP_RST_POWER_CONTROL_REGISTER = 8'h00;
   localparam logic [7:0] SMAP_RST_PEN2 = 8'h00;
   localparam logic [7:0] SMAP_RST_PSW = 8'h00;
   localparam logic [7:0] SMAP_RST_MEMCFG = 8'h00;
   localparam logic [7:0] SMAP_RST_FLAGS = 8'h00;
   localparam logic [7:0] SMAP_MEMCFG_MASK = 8'hC1;

   localparam int SMAP_PAGE_BIT = 0;
   localparam int SMAP_INDEN_BIT = 4;
   localparam int SMAP_CODERAM_BIT = 4;
   localparam int SMAP_BANK_HI_BIT = 4;
   localparam int SMAP_BANK_LO_BIT = 3;
   localparam int SMAP_WRK_DIR_BIT = 7;

   localparam int SMAP_IRAM_DEPTH = 256;
   localparam int SMAP_XRAM_DEPTH = 4096;
   localparam logic [15:0] SMAP_XRAM_LIMIT = 16'h1000;
endpackage

// ==== logic/smap_sfr_paging.sv ====
// paging, stack, scratch pad and on-chip data/code ram of the core
// assumes the core issues one request per cycle and peripherals
// answer an sfr read strobe with data in the same cycle
// Summary of operation
// R1 - stack pointer holds address of newest stack item, incremented per push
// R2 - stack pointer resets to 07h, software may write any 00h..FFh value
// R3 - call or interrupt entry pushes 16-bit return address as two bytes
// R4 - two peripheral pages both decode into direct addresses 80h..FFh
// R5 - two-wire, spi, pulse counter, memory config registers only on page 0; here memory config at F6h decodes on page 1 too
// R6 - arithmetic unit only on page 1, chosen by page select bit set
// R7 - clearing page select bit returns decoding to page 0
// R8 - page select is bit 0 of memory config register at F6h
// R9 - power control bit 4 makes opcode A5h indirect sfr access, else no-op
// R10 - second code byte gives physical ram address 00h..1Fh of working register
// R11 - software stores target with bit 7 clear and data in accumulator for write
// R12 - indirect write copies accumulator into the addressed peripheral register
// R13 - target with bit 7 set reads register content into accumulator
// R14 - 00h..1Fh hold four banks of eight working registers, one active
// R15 - status word bits 4:3 place the bank at 00h, 08h, 10h or 18h
// R16 - general flag byte at F8h resets to 00h, general storage
// R17 - lower 128 scratch bytes direct or indirect, upper 128 indirect only
// R18 - direct addresses 80h..FFh go to peripheral registers, not scratch ram
// R19 - 4KB on-chip ram at data addresses 0000h..0FFFh, always active
// R20 - on-chip ram accesses cause no activity on external bus pins; here only the strobes stay low, extBus.addr and data follow every request
// R21 - code fetch select bit 4 serves fetches below 1000h from on-chip ram
// R22 - software runs above 0FFFh before enabling, then jumps to copied code
// R23 - pop reads item at stack pointer and then decrements by one
`timescale 1ns/1ps
module smap_sfr_paging
   import smap_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire smap_req_t req,
   input wire logic [7:0] sfrRdData,
   output smap_rsp_t rsp,
   output smap_sfr_t sfrBus,
   output smap_ext_t extBus,
   output logic codeFromRam
);
   logic [7:0] iram [0:SMAP_IRAM_DEPTH-1];
   logic [7:0] xram [0:SMAP_XRAM_DEPTH-1];
   logic [7:0] stackPointer;
   logic [7:0] powerControl;
   logic [7:0] periphEnableTwo;
   logic [7:0] statusWord;
   logic [7:0] memoryConfig;
   logic [7:0] generalFlags;
   logic pendValid;
   logic pendLocal;
   logic pendAcc;
   logic [15:0] pendData;

   // local register readback, shared by direct and indirect paths
   function automatic logic [8:0] localRead(input logic [7:0] a, input logic [7:0] spv,
         input logic [7:0] pc, input logic [7:0] pe, input logic [7:0] ps,
         input logic [7:0] mc, input logic [7:0] gf);
      logic [8:0] r;
      r = 9'h000;
      case (a)
         SMAP_ADDR_SP: r = {1'b1, spv};
         SMAP_ADDR_POWER_CONTROL_REGISTER: r = {1'b1, pc};
         SMAP_ADDR_PEN2: r = {1'b1, pe};
         SMAP_ADDR_PSW: r = {1'b1, ps};
         SMAP_ADDR_MEMCFG: r = {1'b1, mc & SMAP_MEMCFG_MASK};
         SMAP_ADDR_FLAGS: r = {1'b1, gf};
         default: r = 9'h000;
      endcase
      return r;
   endfunction

   wire smap_cmd_t cmd = req.cmd;
   wire [7:0] a8 = req.addr[7:0];
   wire dirLow = ~a8[7]; // R17
   wire isDirRd = (cmd == SMAP_DIR_RD);
   wire isDirWr = (cmd == SMAP_DIR_WR);
   wire isSfrInd = (cmd == SMAP_SFR_IND);
   wire indEnable = powerControl[SMAP_INDEN_BIT]; // R9
   wire [7:0] wrkValue = iram[{3'b000, a8[4:0]}]; // R10
   wire indActive = isSfrInd & indEnable; // R9
   wire indIsWr = indActive & ~wrkValue[SMAP_WRK_DIR_BIT]; // R12
   wire indIsRd = indActive & wrkValue[SMAP_WRK_DIR_BIT]; // R13
   // direct high addresses reach the peripheral area
   wire sfrWr = (isDirWr & ~dirLow) | indIsWr; // R18
   wire sfrRd = (isDirRd & ~dirLow) | indIsRd; // R18
   wire [7:0] sfrAddr = isSfrInd ? {1'b1, wrkValue[6:0]} : a8; // R12
   wire [8:0] localHit = localRead(sfrAddr, stackPointer, powerControl, periphEnableTwo,
      statusWord, memoryConfig, generalFlags);
   wire localWr = sfrWr & localHit[8];
   wire extSfrWr = sfrWr & ~localHit[8];
   wire extSfrRd = sfrRd & ~localHit[8];

   wire [7:0] bankBase = {3'b000, statusWord[SMAP_BANK_HI_BIT],
      statusWord[SMAP_BANK_LO_BIT], 3'b000}; // R15
   wire [7:0] regAddr = bankBase | {5'b00000, a8[2:0]}; // R14
   wire [7:0] spPlus1 = stackPointer + 8'h01;
   wire [7:0] spPlus2 = stackPointer + 8'h02;
   wire [7:0] spMinus1 = stackPointer - 8'h01;

   wire xLocal = (req.addr < SMAP_XRAM_LIMIT); // R19
   wire [11:0] xAddr = req.addr[11:0];
   wire fetchLocal = codeFromRam & xLocal; // R21

   // scratch pad write port selection
   wire ramWr = (isDirWr & dirLow) | (cmd == SMAP_IND_WR) | (cmd == SMAP_REG_WR)
      | (cmd == SMAP_PUSH) | (cmd == SMAP_CALL);
   wire [7:0] ramWrAddr = (cmd == SMAP_REG_WR) ? regAddr
      : ((cmd == SMAP_PUSH) | (cmd == SMAP_CALL)) ? spPlus1 : a8; // R1
   wire [7:0] ramWrData = (cmd == SMAP_CALL) ? a8 : req.data; // R3
   wire ramWrHigh = (cmd == SMAP_CALL); // R3
   wire xWr = (cmd == SMAP_XDATA_WR) & xLocal; // R19

   wire [7:0] next_stackPointer =
      (cmd == SMAP_PUSH) ? spPlus1 : // R1
      (cmd == SMAP_CALL) ? spPlus2 : // R3
      (cmd == SMAP_POP) ? spMinus1 : // R23
      (cmd == SMAP_RET) ? stackPointer - 8'h02 :
      (localWr & (sfrAddr == SMAP_ADDR_SP)) ? req.data : stackPointer; // R2

   // read data of this request, when served locally
   wire [15:0] readLocal =
      (isDirRd & dirLow) ? {8'h00, iram[a8]} : // R17
      (cmd == SMAP_IND_RD) ? {8'h00, iram[a8]} : // R17
      (cmd == SMAP_REG_RD) ? {8'h00, iram[regAddr]} : // R14
      (cmd == SMAP_POP) ? {8'h00, iram[stackPointer]} : // R23
      (cmd == SMAP_RET) ? {iram[stackPointer], iram[spMinus1]} :
      ((cmd == SMAP_XDATA_RD) | (cmd == SMAP_FETCH)) ? {8'h00, xram[xAddr]} :
      {8'h00, localHit[7:0]};
   wire answers = (isDirRd & dirLow) | (cmd == SMAP_IND_RD) | (cmd == SMAP_REG_RD)
      | (cmd == SMAP_POP) | (cmd == SMAP_RET) | ((cmd == SMAP_XDATA_RD) & xLocal)
      | ((cmd == SMAP_FETCH) & fetchLocal) | sfrRd;

   // external data traffic only outside on-chip ram, code traffic for every fetch that on-chip ram does not serve
   wire next_extRd = (cmd == SMAP_XDATA_RD) & ~xLocal; // R20
   wire next_extWr = (cmd == SMAP_XDATA_WR) & ~xLocal; // R20
   wire next_fetch = (cmd == SMAP_FETCH) & ~fetchLocal; // R21

   always_ff @(posedge mclk) begin
      if (ramWr) begin
         iram[ramWrAddr] <= ramWrData;
      end
      if (ramWrHigh) begin
         iram[spPlus2] <= req.addr[15:8]; // R3
      end
      if (xWr) begin
         xram[xAddr] <= req.data; // R19
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stackPointer <= SMAP_RST_SP; // R2
         powerControl <= SMAP_RST_POWER_CONTROL_REGISTER;
         periphEnableTwo <= SMAP_RST_PEN2;
         statusWord <= SMAP_RST_PSW;
         memoryConfig <= SMAP_RST_MEMCFG;
         generalFlags <= SMAP_RST_FLAGS; // R16
      end else begin
         stackPointer <= next_stackPointer;
         if (localWr & (sfrAddr == SMAP_ADDR_POWER_CONTROL_REGISTER)) begin
            powerControl <= req.data; // R9
         end
         if (localWr & (sfrAddr == SMAP_ADDR_PEN2)) begin
            periphEnableTwo <= req.data; // R21
         end
         if (localWr & (sfrAddr == SMAP_ADDR_PSW)) begin
            statusWord <= req.data; // R15
         end
         if (localWr & (sfrAddr == SMAP_ADDR_MEMCFG)) begin
            memoryConfig <= req.data & SMAP_MEMCFG_MASK; // R8
         end
         if (localWr & (sfrAddr == SMAP_ADDR_FLAGS)) begin
            generalFlags <= req.data; // R16
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pendValid <= 1'b0;
         pendLocal <= 1'b0;
         pendAcc <= 1'b0;
         pendData <= 16'h0000;
      end else begin
         pendValid <= answers;
         pendLocal <= ~extSfrRd;
         pendAcc <= indIsRd; // R13
         pendData <= readLocal;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sfrBus <= '0;
         extBus <= '0;
         rsp <= '0;
         codeFromRam <= 1'b0;
      end else begin
         sfrBus.wr <= extSfrWr; // R12
         sfrBus.rd <= extSfrRd; // R4
         sfrBus.page <= memoryConfig[SMAP_PAGE_BIT]; // R6 R7 R5
         sfrBus.addr <= sfrAddr; // R4
         sfrBus.data <= req.data; // R12
         extBus.dataRd <= next_extRd;
         extBus.dataWr <= next_extWr;
         extBus.fetch <= next_fetch;
         extBus.addr <= req.addr;
         extBus.data <= req.data;
         rsp.valid <= pendValid;
         rsp.accLoad <= pendValid & pendAcc;
         rsp.data <= pendLocal ? pendData : {8'h00, sfrRdData};
         codeFromRam <= periphEnableTwo[SMAP_CODERAM_BIT]; // R21
      end
   end
endmodule

// ==== tb/smap_sfr_paging_properties.sv ====
// port assertions for the paging and memory map block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module smap_sfr_paging_properties
   import smap_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire smap_req_t req,
   input wire logic [7:0] sfrRdData,
   input wire smap_rsp_t rsp,
   input wire smap_sfr_t sfrBus,
   input wire smap_ext_t extBus,
   input wire logic codeFromRam
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic xLow = req.addr < SMAP_XRAM_LIMIT;
   wire logic localSfr = req.addr[7:0] inside {SMAP_ADDR_SP, SMAP_ADDR_POWER_CONTROL_REGISTER, SMAP_ADDR_PEN2,
      SMAP_ADDR_PSW, SMAP_ADDR_MEMCFG, SMAP_ADDR_FLAGS};
   sequence xLowRead;
      req.cmd == SMAP_XDATA_RD && xLow;
   endsequence
   sequence xLowAny;
      (req.cmd == SMAP_XDATA_RD || req.cmd == SMAP_XDATA_WR) && xLow;
   endsequence
   xram_read_a: assert property (xLowRead |-> ##2 rsp.valid && !rsp.accLoad)
      else $error("on-chip ram read gave no answer");
   xram_quiet_a: assert property (xLowAny |=> !extBus.dataRd && !extBus.dataWr)
      else $error("on-chip ram access reached the external bus");
   ext_read_a: assert property (req.cmd == SMAP_XDATA_RD && !xLow
      |=> extBus.dataRd && extBus.addr == $past(req.addr)) else $error("external read missing");
   sfr_direct_a: assert property (req.cmd == SMAP_DIR_RD && req.addr[7] && !localSfr
      |=> sfrBus.rd && sfrBus.addr == $past(req.addr[7:0])) else $error("upper direct read lost");
   scratch_low_a: assert property (req.cmd == SMAP_DIR_RD && !req.addr[7] |=> !sfrBus.rd)
      else $error("low direct read reached the peripherals");
   page_follow_a: assert property (req.cmd == SMAP_DIR_WR && req.addr[7:0] == SMAP_ADDR_MEMCFG
      |-> ##2 sfrBus.page == $past(req.data[0], 2)) else $error("page level wrong");
   code_select_a: assert property (req.cmd == SMAP_DIR_WR && req.addr[7:0] == SMAP_ADDR_PEN2
      |-> ##2 codeFromRam == $past(req.data[4], 2)) else $error("code select level wrong");
   fetch_flash_a: assert property (req.cmd == SMAP_FETCH && !xLow |=> extBus.fetch)
      else $error("high fetch not sent outside");
   sfr_write_a: assert property (req.cmd == SMAP_DIR_WR && req.addr[7] && !localSfr
      |=> sfrBus.wr && sfrBus.addr == $past(req.addr[7:0]) && sfrBus.data == $past(req.data))
      else $error("upper direct write lost");
   ext_write_a: assert property (req.cmd == SMAP_XDATA_WR && !xLow
      |=> extBus.dataWr && extBus.addr == $past(req.addr) && extBus.data == $past(req.data))
      else $error("external write missing");
endmodule
bind smap_sfr_paging smap_sfr_paging_properties u_props (.mclk(mclk), .rst(rst), .req(req),
   .sfrRdData(sfrRdData), .rsp(rsp), .sfrBus(sfrBus), .extBus(extBus), .codeFromRam(codeFromRam));

// ==== tb/smap_periph_model.sv ====
// outside peripheral registers answering the block's read strobe
// assumes read data is taken in the strobe cycle
`timescale 1ns/1ps
module smap_periph_model
   import smap_pkg::*;
(
   input wire smap_sfr_t sfrBus,
   output logic [7:0] rdData
);
   // page 0 and page 1 registers hold different content
   wire logic [7:0] pageVal = sfrBus.addr ^ (sfrBus.page ? 8'hA5 : 8'h5A);
   // without a strobe the bus shows the inverse, not the value
   assign rdData = sfrBus.rd ? pageVal : ~pageVal;
endmodule

// ==== tb/smap_sfr_paging_tb_top.sv ====
// self-checking bench for the paging and memory map block
// assumes the peripheral model answers reads in the strobe cycle
`timescale 1ns/1ps
module smap_sfr_paging_tb_top
   import smap_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   smap_req_t req = '{SMAP_NOP, 16'h0000, 8'h00};
   smap_rsp_t rsp;
   smap_sfr_t sfrBus;
   smap_ext_t extBus;
   logic [7:0] sfrRdData;
   logic codeFromRam;
   logic [16:0] expQ[$];
   int miscompares = 0;
   int check_count = 0;
   logic [31:0] seed = 32'h00008040;
   logic [7:0] r;
   always #50 mclk = ~mclk;
   smap_sfr_paging dut (.mclk(mclk), .rst(rst), .req(req), .sfrRdData(sfrRdData), .rsp(rsp),
      .sfrBus(sfrBus), .extBus(extBus), .codeFromRam(codeFromRam));
   smap_periph_model periph (.sfrBus(sfrBus), .rdData(sfrRdData));
   function automatic logic [16:0] pv(logic [7:0] a, logic p);
      return {9'h000, a ^ (p ? 8'hA5 : 8'h5A)};
   endfunction
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic op(smap_cmd_t c, logic [15:0] a, logic [7:0] d);
      @(negedge mclk);
      req <= '{c, a, d};
   endtask
   task automatic rd(smap_cmd_t c, logic [15:0] a, logic [7:0] d, logic [16:0] e);
      expQ.push_back(e);
      op(c, a, d);
   endtask
   task automatic check(logic [16:0] got, logic [16:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(negedge mclk) begin
      if (rsp.valid === 1'b1)
         check({rsp.accLoad, rsp.data}, expQ.size() ? expQ.pop_front() : 17'hx);
   end
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk) rst <= 1'b0;
      rd(SMAP_DIR_RD, 16'h0081, 8'h00, 17'h00007);
      rd(SMAP_DIR_RD, 16'h00F8, 8'h00, 17'h00000);
      r = rnd();
      op(SMAP_PUSH, 16'h0000, r);
      op(SMAP_CALL, 16'h1234, 8'h00);
      rd(SMAP_DIR_RD, 16'h0081, 8'h00, 17'h0000A);
      rd(SMAP_RET, 16'h0000, 8'h00, 17'h01234);
      rd(SMAP_POP, 16'h0000, 8'h00, {9'h000, r});
      rd(SMAP_DIR_RD, 16'h0081, 8'h00, 17'h00007);
      for (int b = 0; b < 4; b++) begin
         r = rnd();
         op(SMAP_DIR_WR, 16'h00D0, {3'b000, b[1:0], 3'b000});
         op(SMAP_REG_WR, 16'h0003, r);
         rd(SMAP_IND_RD, 16'(8 * b + 3), 8'h00, {9'h000, r});
      end
      op(SMAP_DIR_WR, 16'h00D0, 8'h00);
      op(SMAP_DIR_WR, 16'h0087, 8'h10);
      op(SMAP_IND_WR, 16'h0000, 8'h78);
      op(SMAP_SFR_IND, 16'h0000, 8'hAA);
      rd(SMAP_DIR_RD, 16'h00F8, 8'h00, 17'h000AA);
      op(SMAP_IND_WR, 16'h0000, 8'hF8);
      rd(SMAP_SFR_IND, 16'h0000, 8'h00, 17'h100AA);
      op(SMAP_DIR_WR, 16'h0087, 8'h00);
      op(SMAP_IND_WR, 16'h0000, 8'h78);
      op(SMAP_SFR_IND, 16'h0000, 8'h55);
      rd(SMAP_DIR_RD, 16'h00F8, 8'h00, 17'h000AA);
      r = rnd();
      op(SMAP_IND_WR, 16'h0090, r);
      rd(SMAP_DIR_RD, 16'h0090, 8'h00, pv(8'h90, 1'b0));
      rd(SMAP_IND_RD, 16'h0090, 8'h00, {9'h000, r});
      op(SMAP_DIR_WR, 16'h0010, ~r);
      rd(SMAP_IND_RD, 16'h0010, 8'h00, {9'h000, ~r});
      rd(SMAP_DIR_RD, 16'h0010, 8'h00, {9'h000, ~r});
      op(SMAP_DIR_WR, 16'h00C4, 8'h3C);
      op(SMAP_DIR_WR, 16'h00F6, 8'h01);
      rd(SMAP_DIR_RD, 16'h00F6, 8'h00, 17'h00001);
      rd(SMAP_DIR_RD, 16'h00C4, 8'h00, pv(8'hC4, 1'b1));
      op(SMAP_DIR_WR, 16'h00F6, 8'h00);
      rd(SMAP_DIR_RD, 16'h00C4, 8'h00, pv(8'hC4, 1'b0));
      r = rnd();
      op(SMAP_XDATA_WR, 16'h0FFF, r);
      rd(SMAP_XDATA_RD, 16'h0FFF, 8'h00, {9'h000, r});
      op(SMAP_XDATA_WR, 16'h1000, r);
      op(SMAP_XDATA_RD, 16'h1000, 8'h00);
      op(SMAP_FETCH, 16'h2000, 8'h00);
      op(SMAP_DIR_WR, 16'h00B1, 8'h10);
      op(SMAP_FETCH, 16'h2000, 8'h00);
      rd(SMAP_FETCH, 16'h0FFF, 8'h00, {9'h000, r});
      op(SMAP_NOP, 16'h0000, 8'h00);
      repeat (4) @(negedge mclk);
      check(17'(expQ.size()), 17'h00000);
      tally_and_finish();
   end
endmodule
